// File: rtl/dot_pkg.sv
// shared constants and carriers of the dual octal registered transceiver
package dot_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int DOT_HALVES = 2;
    localparam int DOT_DIRS = 2;
    localparam int DOT_CHANNELS = DOT_HALVES * DOT_DIRS;
    localparam int DOT_WIDTH = 8;
    localparam int DOT_FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // channel numbering
    // ------------------------------------------------------------
    localparam int DOT_DIR_A_TO_B = 0;
    localparam int DOT_DIR_B_TO_A = 1;

    // ------------------------------------------------------------
    // pin carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic clk_a_to_b;
        logic clk_b_to_a;
        logic capture_en_a_to_b_n;
        logic capture_en_b_to_a_n;
        logic drive_en_a_to_b_n;
        logic drive_en_b_to_a_n;
        logic [DOT_WIDTH-1:0] port_a_pins;
        logic [DOT_WIDTH-1:0] port_b_pins;
    } dot_half_in_t;

    typedef struct packed {
        logic [DOT_WIDTH-1:0] port_a_out;
        logic [DOT_WIDTH-1:0] port_a_oe_n;
        logic [DOT_WIDTH-1:0] port_b_out;
        logic [DOT_WIDTH-1:0] port_b_oe_n;
    } dot_half_out_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DOT_WIDTH-1:0] DOT_DATA_RST = 8'h00;
    localparam logic [DOT_WIDTH-1:0] DOT_OE_N_RST = 8'hff;
    localparam dot_half_in_t DOT_IN_RST = '{
        clk_a_to_b: 1'b0,
        clk_b_to_a: 1'b0,
        capture_en_a_to_b_n: 1'b1,
        capture_en_b_to_a_n: 1'b1,
        drive_en_a_to_b_n: 1'b1,
        drive_en_b_to_a_n: 1'b1,
        port_a_pins: 8'h00,
        port_b_pins: 8'h00
    };
    // synchroniser stages reset to the idle pin levels, so no false edge or enable after reset
    localparam dot_half_in_t DOT_SYNC_RST = DOT_IN_RST;

endpackage

// File: rtl/dot_top.sv
// dual octal registered transceiver core with capture fifo per direction
`timescale 1ns/1ns

// ------------------------------------------------------------
// capture fifo
// ------------------------------------------------------------
module dot_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    assign o_in_ready = (count_reg != CW'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // storage
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    // write pointer
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
    end

    // read pointer
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
    end

    // fill level
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            count_reg <= '0;
        end else begin
            case ({push, pop})
                2'b10: count_reg <= count_reg + 1'b1;
                2'b01: count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end
endmodule

module dot_top #(
    parameter int WIDTH = dot_pkg::DOT_WIDTH,
    parameter int FIFO_DEPTH = dot_pkg::DOT_FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire dot_pkg::dot_half_in_t i_half [dot_pkg::DOT_HALVES],
    input wire logic [dot_pkg::DOT_CHANNELS-1:0] i_drain_hold,
    output dot_pkg::dot_half_out_t o_half [dot_pkg::DOT_HALVES],
    output logic [dot_pkg::DOT_CHANNELS-1:0] o_capture_ready
);
    import dot_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers and agreement filter
    // ------------------------------------------------------------
    dot_half_in_t sync1_reg [DOT_HALVES];
    dot_half_in_t sync2_reg [DOT_HALVES];
    dot_half_in_t sync3_reg [DOT_HALVES];
    dot_half_in_t filt_reg [DOT_HALVES];
    dot_half_in_t filt_next [DOT_HALVES];

    for (genvar h = 0; h < DOT_HALVES; h++) begin : g_sync
        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                sync1_reg[h] <= DOT_SYNC_RST;
                sync2_reg[h] <= DOT_SYNC_RST;
                sync3_reg[h] <= DOT_SYNC_RST;
            end else begin
                sync1_reg[h] <= i_half[h];
                sync2_reg[h] <= sync1_reg[h];
                sync3_reg[h] <= sync2_reg[h];
            end
        end

        // bit takes new level once stages two and three agree
        assign filt_next[h] = (sync2_reg[h] & ~(sync2_reg[h] ^ sync3_reg[h]))
                            | (filt_reg[h] & (sync2_reg[h] ^ sync3_reg[h]));

        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                filt_reg[h] <= DOT_IN_RST;
            end else begin
                filt_reg[h] <= filt_next[h];
            end
        end
    end

    // ------------------------------------------------------------
    // per direction capture path
    // ------------------------------------------------------------
    logic [WIDTH-1:0] data_reg [DOT_CHANNELS];
    logic [WIDTH-1:0] oe_n_reg [DOT_CHANNELS];

    for (genvar c = 0; c < DOT_CHANNELS; c++) begin : g_chan
        localparam int H = c / DOT_DIRS;
        localparam int D = c % DOT_DIRS;

        logic clk_now;
        logic clk_new;
        logic cap_en_n;
        logic drv_en_n;
        logic [WIDTH-1:0] src_pins;
        logic clk_rise;
        logic cap_evt;
        logic fifo_in_ready;
        logic fifo_out_valid;
        logic [WIDTH-1:0] fifo_out_data;

        assign clk_now = (D == DOT_DIR_A_TO_B) ? filt_reg[H].clk_a_to_b
                                               : filt_reg[H].clk_b_to_a;
        assign clk_new = (D == DOT_DIR_A_TO_B) ? filt_next[H].clk_a_to_b
                                               : filt_next[H].clk_b_to_a;
        assign cap_en_n = (D == DOT_DIR_A_TO_B) ? filt_reg[H].capture_en_a_to_b_n
                                                : filt_reg[H].capture_en_b_to_a_n;
        assign drv_en_n = (D == DOT_DIR_A_TO_B) ? filt_reg[H].drive_en_a_to_b_n
                                                : filt_reg[H].drive_en_b_to_a_n;
        assign src_pins = (D == DOT_DIR_A_TO_B) ? filt_reg[H].port_a_pins[WIDTH-1:0]
                                                : filt_reg[H].port_b_pins[WIDTH-1:0];

        assign clk_rise = !clk_now && clk_new;
        assign cap_evt = clk_rise && !cap_en_n;

        dot_fifo #(
            .W(WIDTH),
            .DEPTH(FIFO_DEPTH)
        ) u_fifo (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_in_valid(cap_evt),
            .o_in_ready(fifo_in_ready),
            .i_in_data(src_pins),
            .o_out_valid(fifo_out_valid),
            .i_out_ready(!i_drain_hold[c]),
            .o_out_data(fifo_out_data)
        );

        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                data_reg[c] <= DOT_DATA_RST;
            end else if (fifo_out_valid && !i_drain_hold[c]) begin
                data_reg[c] <= fifo_out_data;
            end
        end

        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                oe_n_reg[c] <= DOT_OE_N_RST;
            end else begin
                oe_n_reg[c] <= {WIDTH{drv_en_n}};
            end
        end

        // capture back-pressure
        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                o_capture_ready[c] <= 1'b0;
            end else begin
                o_capture_ready[c] <= fifo_in_ready;
            end
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    // reset values float the pins
    for (genvar h = 0; h < DOT_HALVES; h++) begin : g_out
        assign o_half[h].port_b_out = data_reg[h * DOT_DIRS + DOT_DIR_A_TO_B];
        assign o_half[h].port_b_oe_n = oe_n_reg[h * DOT_DIRS + DOT_DIR_A_TO_B];
        assign o_half[h].port_a_out = data_reg[h * DOT_DIRS + DOT_DIR_B_TO_A];
        assign o_half[h].port_a_oe_n = oe_n_reg[h * DOT_DIRS + DOT_DIR_B_TO_A];
    end
endmodule

// File: dv/dot_bus_agent.sv
// bus agent holding one side of a transceiver bus
`timescale 1ns/1ns
module dot_bus_agent (
    input wire logic [7:0] i_val,
    input wire logic [7:0] i_dev_out,
    input wire logic [7:0] i_dev_oe_n,
    output logic [7:0] o_wire
);
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            o_wire[k] = i_dev_oe_n[k] ? i_val[k] : i_dev_out[k];
        end
    end
endmodule

// File: dv/dot_sva.sv
// assertion checker for the transceiver core ports
`timescale 1ns/1ns
module dot_sva_chk #(
    parameter int WIDTH = 8,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire dot_pkg::dot_half_in_t i_half [2],
    input wire logic [3:0] i_drain_hold,
    input wire dot_pkg::dot_half_out_t o_half [2],
    input wire logic [3:0] o_capture_ready
);
    import dot_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // --------
    // checks
    // --------
    // reset state
    rst_clear_a: assert property ($rose(i_rst_n) |-> o_capture_ready == 4'h0 &&
        o_half[1].port_b_oe_n == 8'hff && o_half[0].port_a_out == 8'h00) else $error("bad reset");
    drive_ab_a: assert property (!i_half[0].drive_en_a_to_b_n [*6] |->
        o_half[0].port_b_oe_n == 8'h00) else $error("b not driven");
    float_ba_a: assert property (i_half[1].drive_en_b_to_a_n [*6] |->
        o_half[1].port_a_oe_n == 8'hff) else $error("a not floated");
    oe_cause_a: assert property ($fell(o_half[0].port_a_oe_n[0]) |->
        !$past(i_half[0].drive_en_b_to_a_n, 3)) else $error("a driven early");
    oe_rise_b_a: assert property ($rose(o_half[1].port_b_oe_n[0]) |->
        $past(i_half[1].drive_en_a_to_b_n, 3)) else $error("b released early");
    pop_gate_a: assert property ($changed(o_half[0].port_b_out) |->
        !$past(i_drain_hold[0])) else $error("b out moved while held");
    pop_gate_b_a: assert property ($changed(o_half[1].port_a_out) |->
        !$past(i_drain_hold[3])) else $error("a out moved while held");
    ready_fall_a: assert property ($fell(o_capture_ready[0]) |->
        $past(i_drain_hold[0])) else $error("ready fell unheld");
    cover property ($fell(o_capture_ready[0]));
    cover property ($fell(o_half[0].port_b_oe_n[0]));
    cover property ($changed(o_half[1].port_a_out));
endmodule
bind dot_top dot_sva_chk #(.WIDTH(WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) u_dot_sva_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_half(i_half),
    .i_drain_hold(i_drain_hold), .o_half(o_half), .o_capture_ready(o_capture_ready));

// File: dv/testbench.sv
// self-checking bench for the transceiver core
`timescale 1ns/1ns
module testbench;
    import dot_pkg::*;
    logic clk, rst_n;
    logic [5:0] ctl [2];
    logic [7:0] v [4], want [4];
    logic [3:0] hold_q, rdy;
    logic [18:0] rows [8];
    wire logic [7:0] w [4];
    dot_half_in_t hin [2];
    dot_half_out_t oh [2];
    int fail_count, tests_run;
    for (genvar b = 0; b < 4; b++) begin : g_bus
        dot_bus_agent u_dot_bus_agent (.i_val(v[b]), .o_wire(w[b]),
            .i_dev_out(b % 2 ? oh[b/2].port_b_out : oh[b/2].port_a_out),
            .i_dev_oe_n(b % 2 ? oh[b/2].port_b_oe_n : oh[b/2].port_a_oe_n));
    end
    for (genvar h = 0; h < 2; h++) begin : g_half
        assign hin[h] = {ctl[h], w[2*h], w[2*h+1]};
    end
    dot_top #(.WIDTH(8), .FIFO_DEPTH(16)) u_dot_top (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_half(hin), .i_drain_hold(hold_q), .o_half(oh), .o_capture_ready(rdy));
    function automatic logic [7:0] dout(int c);
        return c % 2 ? oh[c/2].port_a_out : oh[c/2].port_b_out;
    endfunction
    function automatic logic [7:0] doe(int c);
        return c % 2 ? oh[c/2].port_a_oe_n : oh[c/2].port_b_oe_n;
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp_v);
        tests_run++;
        if (got !== exp_v) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp_v);
        end
    endtask
    task automatic cap(int c, logic [7:0] val, logic ce);
        @(posedge clk);
        v[c] <= val;
        ctl[c/2][3-c%2] <= ce;
        repeat (4) @(posedge clk);
        ctl[c/2][5-c%2] <= 1'b1;
        repeat (4) @(posedge clk);
        ctl[c/2][5-c%2] <= 1'b0;
        repeat (4) @(posedge clk);
        ctl[c/2][3-c%2] <= 1'b1;
        @(negedge clk);
    endtask
    task automatic drive(int c, logic en_n);
        @(posedge clk);
        ctl[c/2][1-c%2] <= en_n;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic complete_run;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        ctl = '{6'h0f, 6'h0f};
        v = '{default: 8'h00};
        want = '{default: 8'h00};
        hold_q = 4'h0;
        rows = '{19'h05555, 19'h2aaaa, 19'h40f0f, 19'h6f0f0,
            19'h1ff55, 19'h701f0, 19'h20000, 19'h48080};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        for (int c = 0; c < 4; c++) begin
            chk(dout(c), 8'h00);
            chk(doe(c), 8'hff);
        end
        $display("reset test done");
        for (int r = 0; r < 8; r++) begin
            int c;
            c = int'(rows[r][18:17]);
            cap(c, rows[r][15:8], rows[r][16]);
            want[c] = rows[r][7:0];
            for (int k = 0; k < 4; k++) chk(dout(k), want[k]);
            drive(c, 1'b0);
            chk(doe(c), 8'h00);
            chk(w[c^1], want[c]);
            drive(c, 1'b1);
            chk(doe(c), 8'hff);
            $display("row %0d done", r);
        end
        @(posedge clk);
        hold_q <= 4'h1;
        for (int i = 0; i < 17; i++) cap(0, 8'(i), 1'b0);
        chk({7'h0, rdy[0]}, 8'h00);
        chk(dout(0), want[0]);
        @(posedge clk);
        hold_q <= 4'h0;
        repeat (24) @(posedge clk);
        @(negedge clk);
        chk(dout(0), 8'h0f);
        chk({7'h0, rdy[0]}, 8'h01);
        $display("fifo test done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(negedge clk);
        chk(dout(0), 8'h00);
        chk({4'h0, rdy}, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk(doe(0), 8'hff);
        chk({4'h0, rdy}, 8'h0f);
        $display("reset rerun done");
        complete_run();
    end
endmodule
